// file: baeq_cfg.svh
// constants of the bus activity event qualifier
`ifndef BAEQ_CFG_SVH
`define BAEQ_CFG_SVH
`define BAEQ_AW          8
`define BAEQ_OFF_SEL_A   8'h00
`define BAEQ_OFF_SEL_B   8'h04
`define BAEQ_OFF_CFG     4'h1
`define BAEQ_OFF_STAT    8'h20
`define BAEQ_EV_HI       31
`define BAEQ_EV_LO       25
`define BAEQ_EV_DATA     7'h17
`define BAEQ_EV_ALLOC    7'h03
`define BAEQ_MASK_LO     9
`define BAEQ_SEL_OS      3
`define BAEQ_SEL_USR     2
`define BAEQ_CFG_EN      12
`define BAEQ_CFG_SEL_HI  15
`define BAEQ_CFG_SEL_LO  13
`define BAEQ_CFG_SEL_VAL 3'h6
`define BAEQ_CFG_EDGE    24
`define BAEQ_M_DRV       0
`define BAEQ_M_OWN       1
`define BAEQ_M_OTH       2
`define BAEQ_M_RSV       3
`define BAEQ_M_REQ_HI    4
`define BAEQ_M_RD        5
`define BAEQ_M_WR        6
`define BAEQ_M_MEM_HI    11
`define BAEQ_M_MEM_LO    7
`define BAEQ_M_SRC_OWN   13
`define BAEQ_M_SRC_OTH   14
`define BAEQ_MODEL_NEW   4'h2
`define BAEQ_LEN_PART    3'h2
`define BAEQ_LEN_FULL    3'h4
`define BAEQ_RESP_OKAY   2'h0
`define BAEQ_RESP_ERR    2'h2
`endif

// file: baeq_pkg.sv
// types of the bus activity event qualifier
package baeq_pkg;
  typedef struct packed {
    logic [2:0] cnt;
    logic       act;
  } baeq_str_t;

  typedef struct packed {
    logic [8:0]       sync1;
    logic [8:0]       sync2;
    logic [1:0]       strap_wait;
    logic             strap_done;
    logic [3:0]       model;
    logic [31:0]      sel_a;
    logic [31:0]      sel_b;
    logic [3:0][31:0] cfg;
    logic [3:0]       prev;
    logic [3:0]       pulse;
    logic             last_full;
    logic             awrdy;
    logic             wrdy;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       aw_addr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } baeq_state_t;
endpackage : baeq_pkg

// file: baeq_stretch.sv
// holds a qualifying condition for a partial or full-line length
`include "baeq_cfg.svh"
module baeq_stretch
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // start of a phase and its length
  input  wire logic start_i,
  input  wire logic full_i,
  // held condition
  output logic      active_o
);
  baeq_pkg::baeq_str_t s_ff;
  baeq_pkg::baeq_str_t nxt_s;

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    if (start_i)
    begin
      // a new phase restarts the hold, so stalls repeat it
      nxt_s.cnt = full_i ? `BAEQ_LEN_FULL - 3'h1
                         : `BAEQ_LEN_PART - 3'h1;
      nxt_s.act = 1'b1;
    end
    else if (s_ff.cnt != 3'h0)
    begin
      nxt_s.cnt = s_ff.cnt - 3'h1;
    end
    else
    begin
      nxt_s.act = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign active_o = s_ff.act;

  // ==========================================================
  // checks
  a_full_hold: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    start_i && full_i |=> active_o [*4])
    else $error("full-line condition not held four clocks");

  a_part_end: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    start_i && !full_i ##1 !start_i ##1 !start_i |=> !active_o)
    else $error("partial condition held past two clocks");
endmodule : baeq_stretch

// file: baeq_top.sv
// bus activity event qualifier with its AXI4-Lite register file
// Contract
// - count each data ready or busy event
// - select a feeds counters 0,1; b feeds 2,3
// - mask bit 0 counts self-driven data
// - driven data held 2 or 4 clocks
// - mask bit 1 counts self-sampled data, 2/4
// - mask bit 2 counts data not sampled here
// - foreign data held 2 or 4 clocks
// - mask bit 3 counts own reservation, full only
// - reservation may repeat during lock stall
// - model 2 up: all allocation terms ANDed
// - older: any term ORed, then source ANDed
// - read/write-all bits ignore memory-type bits
// - allocation count ignores privilege level
// - allocation counts a line or a chunk
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`include "baeq_cfg.svh"
module baeq_top
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // bus pins and strap
  input  wire logic        data_ready_phase_i,
  input  wire logic        data_busy_reserve_i,
  input  wire logic        xfer_full_line_i,
  input  wire logic        xfer_self_drive_i,
  input  wire logic        xfer_self_sample_i,
  input  wire logic [3:0]  model_code_i,
  // queue allocation from core logic
  input  wire logic        alloc_valid_i,
  input  wire logic [4:0]  alloc_req_type_i,
  input  wire logic        alloc_read_i,
  input  wire logic        alloc_write_i,
  input  wire logic [4:0]  alloc_mem_type_i,
  input  wire logic        alloc_src_own_i,
  input  wire logic        alloc_src_other_i,
  input  wire logic        alloc_full_line_i,
  input  wire logic        privilege_level_user_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // count pulses to the counter core
  output logic [3:0]       count_pulse_o,
  output logic             count_unit_full_o
);
  baeq_pkg::baeq_state_t s_ff;
  baeq_pkg::baeq_state_t nxt_s;

  logic [3:0] start;
  logic [3:0] len4;
  logic [3:0] act;
  logic [1:0] cond_bank;
  logic [3:0] live;
  logic [3:0] edge_on;

  // ==========================================================
  // condition hold per data activity kind
  always_comb
  begin
    start[0] = s_ff.sync2[0] && s_ff.sync2[3];
    start[1] = s_ff.sync2[0] && s_ff.sync2[4];
    start[2] = s_ff.sync2[0] && !s_ff.sync2[4];
    start[3] = s_ff.sync2[1] && s_ff.sync2[3] && s_ff.sync2[2];
    len4     = {1'b0, {3{s_ff.sync2[2]}}};
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hold
      baeq_stretch u_hold
      (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (start[g]),
        .full_i    (len4[g]),
        .active_o  (act[g])
      );
    end
  endgenerate

  // ==========================================================
  // queue allocation trigger for one mask
  function automatic logic alloc_hit(input logic [15:0] m,
                                     input logic        newer);
    logic req;
    logic rw;
    logic mem;
    logic src;
    logic any_rw;
    req    = m[`BAEQ_M_REQ_HI:0] == alloc_req_type_i;
    rw     = (m[`BAEQ_M_RD] && alloc_read_i) ||
             (m[`BAEQ_M_WR] && alloc_write_i);
    any_rw = m[`BAEQ_M_RD] || m[`BAEQ_M_WR];
    mem    = |(m[`BAEQ_M_MEM_HI:`BAEQ_M_MEM_LO] & alloc_mem_type_i);
    src    = (m[`BAEQ_M_SRC_OWN] && alloc_src_own_i) ||
             (m[`BAEQ_M_SRC_OTH] && alloc_src_other_i);
    if (newer)
    begin
      alloc_hit = req && rw && (mem || any_rw) && src;
    end
    else
    begin
      alloc_hit = (req || rw || (mem && !any_rw)) && src;
    end
  endfunction : alloc_hit

  // data activity condition for one event select
  function automatic logic bank_cond(input logic [31:0] sel,
                                     input logic [3:0]  a,
                                     input logic        newer);
    logic [15:0] m;
    logic        priv_ok;
    m = sel[`BAEQ_MASK_LO+15:`BAEQ_MASK_LO];
    priv_ok = privilege_level_user_i ? sel[`BAEQ_SEL_USR]
                                     : sel[`BAEQ_SEL_OS];
    bank_cond = 1'b0;
    if (sel[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_DATA)
    begin
      bank_cond = priv_ok && |(m[`BAEQ_M_RSV:0] & a);
    end
    else if (sel[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_ALLOC)
    begin
      // privilege filter does not apply here
      bank_cond = alloc_valid_i && alloc_hit(m, newer);
    end
  endfunction : bank_cond

  // ==========================================================
  // register write with byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ==========================================================
  // next state
  always_comb
  begin
    logic        newer;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic        ok;
    nxt_s = s_ff;
    ra    = '0;
    rd    = '0;
    ok    = 1'b0;
    newer = s_ff.model >= `BAEQ_MODEL_NEW;

    // pin synchronisers and strap capture after reset release
    nxt_s.sync1 = {model_code_i, xfer_self_sample_i, xfer_self_drive_i,
                   xfer_full_line_i, data_busy_reserve_i,
                   data_ready_phase_i};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.strap_wait = {s_ff.strap_wait[0], 1'b1};
    if (s_ff.strap_wait[1] && !s_ff.strap_done)
    begin
      nxt_s.model      = s_ff.sync2[8:5];
      nxt_s.strap_done = 1'b1;
    end

    // counter feeds
    cond_bank[0] = bank_cond(s_ff.sel_a, act, newer);
    cond_bank[1] = bank_cond(s_ff.sel_b, act, newer);
    for (int k = 0; k < 4; k++)
    begin
      live[k] = s_ff.cfg[k][`BAEQ_CFG_EN] &&
                s_ff.cfg[k][`BAEQ_CFG_SEL_HI:`BAEQ_CFG_SEL_LO] ==
                `BAEQ_CFG_SEL_VAL;
      edge_on[k] = s_ff.cfg[k][`BAEQ_CFG_EDGE];
      nxt_s.prev[k] = cond_bank[k/2];
      nxt_s.pulse[k] = live[k] && cond_bank[k/2] &&
                       !(edge_on[k] && s_ff.prev[k]);
    end
    if (alloc_valid_i)
    begin
      nxt_s.last_full = alloc_full_line_i;
    end

    // write channel
    if (s_axi_awvalid && s_ff.awrdy)
    begin
      nxt_s.aw_addr = s_axi_awaddr;
      nxt_s.aw_held = 1'b1;
      nxt_s.awrdy   = 1'b0;
    end
    if (s_axi_wvalid && s_ff.wrdy)
    begin
      nxt_s.wdata  = s_axi_wdata;
      nxt_s.wstrb  = s_axi_wstrb;
      nxt_s.w_held = 1'b1;
      nxt_s.wrdy   = 1'b0;
    end
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid)
    begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = `BAEQ_RESP_OKAY;
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held  = 1'b0;
      if (s_ff.aw_addr == `BAEQ_OFF_SEL_A)
      begin
        nxt_s.sel_a = merge(s_ff.sel_a, s_ff.wdata, s_ff.wstrb);
      end
      else if (s_ff.aw_addr == `BAEQ_OFF_SEL_B)
      begin
        nxt_s.sel_b = merge(s_ff.sel_b, s_ff.wdata, s_ff.wstrb);
      end
      else if (s_ff.aw_addr[7:4] == `BAEQ_OFF_CFG &&
               s_ff.aw_addr[1:0] == 2'h0)
      begin
        nxt_s.cfg[s_ff.aw_addr[3:2]] =
          merge(s_ff.cfg[s_ff.aw_addr[3:2]], s_ff.wdata, s_ff.wstrb);
      end
      else if (s_ff.aw_addr != `BAEQ_OFF_STAT)
      begin
        nxt_s.bresp = `BAEQ_RESP_ERR;
      end
    end
    if (s_ff.bvalid && s_axi_bready)
    begin
      nxt_s.bvalid = 1'b0;
      nxt_s.awrdy  = 1'b1;
      nxt_s.wrdy   = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && s_ff.arrdy)
    begin
      ra = s_axi_araddr;
      ok = 1'b1;
      if (ra == `BAEQ_OFF_SEL_A)
      begin
        rd = s_ff.sel_a;
      end
      else if (ra == `BAEQ_OFF_SEL_B)
      begin
        rd = s_ff.sel_b;
      end
      else if (ra[7:4] == `BAEQ_OFF_CFG && ra[1:0] == 2'h0)
      begin
        rd = s_ff.cfg[ra[3:2]];
      end
      else if (ra == `BAEQ_OFF_STAT)
      begin
        rd = {18'h0, s_ff.strap_done, s_ff.last_full, s_ff.model,
              s_ff.prev, act};
      end
      else
      begin
        ok = 1'b0;
      end
      nxt_s.rdata  = rd;
      nxt_s.rresp  = ok ? `BAEQ_RESP_OKAY : `BAEQ_RESP_ERR;
      nxt_s.rvalid = 1'b1;
      nxt_s.arrdy  = 1'b0;
    end
    if (s_ff.rvalid && s_axi_rready)
    begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arrdy  = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_ff       <= '0;
      s_ff.awrdy <= 1'b1;
      s_ff.wrdy  <= 1'b1;
      s_ff.arrdy <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready     = s_ff.awrdy;
  assign s_axi_wready      = s_ff.wrdy;
  assign s_axi_bvalid      = s_ff.bvalid;
  assign s_axi_bresp       = s_ff.bresp;
  assign s_axi_arready     = s_ff.arrdy;
  assign s_axi_rvalid      = s_ff.rvalid;
  assign s_axi_rdata       = s_ff.rdata;
  assign s_axi_rresp       = s_ff.rresp;
  assign count_pulse_o     = s_ff.pulse;
  assign count_unit_full_o = s_ff.last_full;

  // ==========================================================
  // checks
  a_bank_split: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.pulse[0] || s_ff.pulse[1] |-> $past(cond_bank[0]))
    else $error("counter 0 or 1 fed without select a");

  a_drv_count: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.sel_a[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_DATA &&
    s_ff.sel_a[`BAEQ_MASK_LO] && s_ff.sel_a[`BAEQ_SEL_USR] &&
    s_ff.sel_a[`BAEQ_SEL_OS] && act[0] && live[0] && !edge_on[0]
    |=> s_ff.pulse[0])
    else $error("driven data not counted");

  a_own_count: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    start[1] && s_ff.sel_b[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_DATA &&
    s_ff.sel_b[`BAEQ_MASK_LO+1] && s_ff.sel_b[`BAEQ_SEL_USR] &&
    s_ff.sel_b[`BAEQ_SEL_OS] && live[2] && !edge_on[2]
    ##1 live[2] && !edge_on[2] && $stable(s_ff.sel_b)
    |=> s_ff.pulse[2])
    else $error("sampled data not counted");

  a_foreign_data: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.sel_a[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_DATA &&
    s_ff.sel_a[`BAEQ_MASK_LO+2] && s_ff.sel_a[`BAEQ_SEL_USR] &&
    s_ff.sel_a[`BAEQ_SEL_OS] && act[2] && live[1] && !edge_on[1]
    |=> s_ff.pulse[1])
    else $error("foreign data not counted");

  a_rsv_full: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !$past(start[3]) && !$past(start[3], 2) |-> !act[3])
    else $error("reservation held without full-line write");

  a_alloc_new: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.model >= `BAEQ_MODEL_NEW && alloc_valid_i &&
    s_ff.sel_a[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_ALLOC &&
    live[0] && !edge_on[0] && !alloc_src_own_i && !alloc_src_other_i
    |=> !s_ff.pulse[0])
    else $error("allocation counted without source match");

  a_alloc_old: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.model < `BAEQ_MODEL_NEW && alloc_valid_i &&
    s_ff.sel_a[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_ALLOC &&
    s_ff.sel_a[`BAEQ_MASK_LO+`BAEQ_M_RD] && alloc_read_i &&
    s_ff.sel_a[`BAEQ_MASK_LO+`BAEQ_M_SRC_OWN] && alloc_src_own_i &&
    live[0] && !edge_on[0] |=> s_ff.pulse[0])
    else $error("older model allocation term not ORed");

  a_mem_ignore: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ff.model >= `BAEQ_MODEL_NEW && alloc_valid_i &&
    s_ff.sel_a[`BAEQ_EV_HI:`BAEQ_EV_LO] == `BAEQ_EV_ALLOC &&
    s_ff.sel_a[`BAEQ_MASK_LO+4:`BAEQ_MASK_LO] == alloc_req_type_i &&
    s_ff.sel_a[`BAEQ_MASK_LO+`BAEQ_M_WR] && alloc_write_i &&
    s_ff.sel_a[`BAEQ_MASK_LO+`BAEQ_M_SRC_OTH] && alloc_src_other_i &&
    live[0] && !edge_on[0] |=> s_ff.pulse[0])
    else $error("memory type not ignored with write-all");
endmodule : baeq_top

// file: baeq_bus_agent.sv
// far-side bus agent model driving data phase and reservation pins
module baeq_bus_agent
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // command from the bench
  input  wire logic go_i,
  input  wire logic rsv_i,
  input  wire logic full_i,
  input  wire logic drv_i,
  input  wire logic smp_i,
  // bus pins
  output logic      ready_o,
  output logic      busy_o,
  output logic      full_o,
  output logic      drv_o,
  output logic      smp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pin driver
  // qualifiers toggle outside a phase so no stale value looks valid
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {ready_o, busy_o, full_o, drv_o, smp_o} <= 5'h00;
    else if (go_i)
      {ready_o, busy_o, full_o, drv_o, smp_o} <=
        {!rsv_i, rsv_i, full_i, drv_i, smp_i};
    else
      {ready_o, busy_o, full_o, drv_o, smp_o} <=
        {2'h0, ~full_o, ~drv_o, ~smp_o};
  end
endmodule : baeq_bus_agent

// file: baeq_top_test.sv
// self-checking bench of the bus activity event qualifier
`include "baeq_cfg.svh"
`define CHK(nm, ex, got) \
  total_checks++; \
  if ((got) !== (ex)) \
  begin \
    fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
  end
module baeq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bench state and design signals
  int          fail_count   = 0;
  int          total_checks = 0;
  int          pc[4];
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        go = 1'b0, rsv = 1'b0, full = 1'b0, drv = 1'b0, smp = 1'b0;
  logic        rdy_p, bsy_p, full_p, drv_p, smp_p;
  logic [3:0]  model_code_i = 4'h0;
  logic        alloc_valid_i = 1'b0, alloc_read_i = 1'b0;
  logic        alloc_write_i = 1'b0, alloc_src_own_i = 1'b0;
  logic        alloc_src_other_i = 1'b0, alloc_full_line_i = 1'b0;
  logic [4:0]  alloc_req_type_i = 5'h00, alloc_mem_type_i = 5'h00;
  logic        privilege_level_user_i = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, count_unit_full_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0]  count_pulse_o;
  localparam logic [4:0] rq_tab [5] = '{5'h01, 5'h02, 5'h01, 5'h01, 5'h01};
  localparam logic [4:0] mt_tab [5] = '{5'h01, 5'h02, 5'h02, 5'h01, 5'h01};
  localparam logic [4:0] rd_tab  = 5'b01110;
  // row 3 has no source agent, row 4 is a write from another agent
  localparam logic [4:0] own_tab = 5'b00111;
  localparam logic [4:0] oth_tab = 5'b10000;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i)
    for (int k = 0; k < 4; k++) pc[k] += int'(count_pulse_o[k]);

  baeq_bus_agent u_agent (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .go_i(go), .rsv_i(rsv), .full_i(full), .drv_i(drv), .smp_i(smp),
    .ready_o(rdy_p), .busy_o(bsy_p), .full_o(full_p), .drv_o(drv_p),
    .smp_o(smp_p));

  baeq_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .data_ready_phase_i(rdy_p), .data_busy_reserve_i(bsy_p),
    .xfer_full_line_i(full_p), .xfer_self_drive_i(drv_p),
    .xfer_self_sample_i(smp_p), .model_code_i(model_code_i),
    .alloc_valid_i(alloc_valid_i), .alloc_req_type_i(alloc_req_type_i),
    .alloc_read_i(alloc_read_i), .alloc_write_i(alloc_write_i),
    .alloc_mem_type_i(alloc_mem_type_i), .alloc_src_own_i(alloc_src_own_i),
    .alloc_src_other_i(alloc_src_other_i),
    .alloc_full_line_i(alloc_full_line_i),
    .privilege_level_user_i(privilege_level_user_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .count_pulse_o(count_pulse_o),
    .count_unit_full_o(count_unit_full_o));

  // ==========================================================
  // bus and pin tasks
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    `CHK("write answer", 1'b1, s_axi_bvalid)
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    `CHK("read answer", 1'b1, s_axi_rvalid)
  endtask : rd

  task automatic cfg_all(input logic [31:0] sa, sb, input logic [3:0] ed);
    logic [1:0] r;
    wr(`BAEQ_OFF_SEL_A, sa, r);
    wr(`BAEQ_OFF_SEL_B, sb, r);
    for (int k = 0; k < 4; k++)
      wr(8'h10 + 8'(4 * k), 32'h0000d000 | (32'(ed[k]) << 24), r);
  endtask : cfg_all

  task automatic phase(input logic rv, fl, dv, sm);
    @(posedge clk_sys_i);
    {go, rsv, full, drv, smp} <= {1'b1, rv, fl, dv, sm};
    @(posedge clk_sys_i);
    go <= 1'b0;
  endtask : phase

  function automatic logic alloc_exp(input logic nw, input logic [15:0] m,
                                     input int v);
    logic q, w, t, s;
    q = (rq_tab[v] == m[4:0]);
    w = (m[5] & rd_tab[v]) | (m[6] & (v == 4));
    t = (m[5] | m[6]) ? nw : |(mt_tab[v] & m[11:7]);
    s = (m[13] & own_tab[v]) | (m[14] & oth_tab[v]);
    return nw ? (q & w & t & s) : ((q | w | t) & s);
  endfunction : alloc_exp

  // ==========================================================
  // scenarios
  task automatic reg_check;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`BAEQ_OFF_SEL_A, 32'h2e00_1e0c, r);
    rd(`BAEQ_OFF_SEL_A, d, r);
    `CHK("select a readback", 32'h2e00_1e0c, d)
    wr(8'h40, 32'hffff_ffff, r);
    `CHK("unmapped bresp", `BAEQ_RESP_ERR, r)
    rd(8'h40, d, r);
    `CHK("unmapped rresp", `BAEQ_RESP_ERR, r)
    `CHK("unmapped rdata", 32'h0, d)
    wr(`BAEQ_OFF_STAT, 32'h0, r);
    `CHK("status bresp", `BAEQ_RESP_OKAY, r)
    rd(`BAEQ_OFF_STAT, d, r);
    `CHK("strap latched", 1'b1, d[13])
  endtask : reg_check

  task automatic run_row(input logic [3:0] m, input int n,
                         input logic rv, fl, dv, sm, input int ex);
    cfg_all({7'h17, 12'h000, m, 9'h00c}, 32'h0, 4'h0);
    pc = '{default: 0};
    repeat (n) phase(rv, fl, dv, sm);
    repeat (12) @(posedge clk_sys_i);
    `CHK("pulses ctr0", ex, pc[0])
    `CHK("pulses ctr1", ex, pc[1])
    `CHK("pulses ctr2", 0, pc[2])
    `CHK("pulses ctr3", 0, pc[3])
  endtask : run_row

  task automatic bank_b;
    cfg_all(32'h0, {7'h17, 16'h0003, 9'h00c}, 4'h8);
    pc = '{default: 0};
    phase(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    phase(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (12) @(posedge clk_sys_i);
    `CHK("bank b ctr0", 0, pc[0])
    `CHK("bank b edge ctr3", 2, pc[3])
    `CHK("bank b level ctr2", 6, pc[2])
  endtask : bank_b

  task automatic alloc_run(input logic [3:0] md);
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] msk;
    logic        ex;
    model_code_i <= md;
    do_reset();
    rd(`BAEQ_OFF_STAT, d, r);
    `CHK("model strap", md, d[11:8])
    for (int mi = 0; mi < 2; mi++)
    begin
      msk = (mi == 1) ? 16'h60e1 : 16'h2081;
      cfg_all({7'h03, msk, 9'h000}, {7'h03, msk, 9'h000}, 4'h0);
      for (int v = 0; v < 5; v++)
      begin
        pc = '{default: 0};
        @(posedge clk_sys_i);
        {alloc_valid_i, alloc_req_type_i, alloc_read_i, alloc_write_i,
         alloc_mem_type_i, alloc_src_own_i, alloc_src_other_i,
         alloc_full_line_i} <= {1'b1, rq_tab[v], rd_tab[v], v == 4,
         mt_tab[v], own_tab[v], oth_tab[v], v[0]};
        @(posedge clk_sys_i);
        alloc_valid_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        ex = alloc_exp(md >= `BAEQ_MODEL_NEW, msk, v);
        `CHK("alloc ctr0", int'(ex), pc[0])
        `CHK("alloc ctr3", int'(ex), pc[3])
        if (ex)
        begin
          `CHK("alloc unit", v[0], count_unit_full_o)
        end
      end
    end
  endtask : alloc_run

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    do_reset();
    reg_check();
    run_row(4'h1, 1, 1'b0, 1'b1, 1'b1, 1'b0, 4);
    run_row(4'h1, 1, 1'b0, 1'b0, 1'b1, 1'b0, 2);
    run_row(4'h1, 1, 1'b0, 1'b1, 1'b0, 1'b1, 0);
    run_row(4'h2, 1, 1'b0, 1'b1, 1'b0, 1'b1, 4);
    run_row(4'h2, 1, 1'b0, 1'b0, 1'b0, 1'b1, 2);
    run_row(4'h4, 1, 1'b0, 1'b1, 1'b1, 1'b0, 4);
    run_row(4'h4, 1, 1'b0, 1'b0, 1'b0, 1'b0, 2);
    run_row(4'h4, 1, 1'b0, 1'b1, 1'b0, 1'b1, 0);
    run_row(4'h8, 1, 1'b1, 1'b1, 1'b1, 1'b0, 2);
    run_row(4'h8, 1, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    run_row(4'h8, 2, 1'b1, 1'b1, 1'b1, 1'b0, 4);
    run_row(4'h3, 1, 1'b0, 1'b1, 1'b1, 1'b0, 4);
    bank_b();
    alloc_run(4'h0);
    alloc_run(`BAEQ_MODEL_NEW);
    close_out();
  end

  initial
  begin
    #200us;
    fail_count++;
    close_out();
  end
endmodule : baeq_top_test
